// ### rtl/sdr_pkg.sv
// Behaviour
// - The coast duration field (bits 12:9) selects one of sixteen times from 10 ms to 15 s.
// - The stationary field (bits 8:6) selects a back-EMF threshold from 50 mV to 1500 mV.
// - The hand-off field (bits 5:2) selects a speed from 2.5 % to 100 % of maximum.
// - The reversal current field (bits 1:0) selects 0.9375, 1.5625, 2.1875 or 3.125 A.
// - The reverse-drive word sits at offset 82h, resets to zero, bit 31 reserved, all else read/write.
// - Bits 30:27 select the first-order reverse acceleration, 0.01 Hz/s to 10000 Hz/s.
// - Bits 26:23 select the second-order reverse acceleration, 0.0 to 10000 Hz/s2.
// - Bits 22:20 select the active-brake bus current limit, 0.3125 A to 3.75 A, code 7 reserved.
// - Bits 19:10 hold the braking proportional gain, effective gain being value over 27.
// - Bits 9:0 hold the braking integral gain, effective gain being value over 29.
// - Reverse drive is enabled only while bit 27 of the speed-detect word is set.
// - The coast phase is applied only while bit 28 of the speed-detect word is set.
package sdr_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// Printed offsets are word indices; byte address is four times them
	localparam logic [7:0]  IDX_ISD       = 8'h80;
	localparam logic [7:0]  IDX_REV       = 8'h82;
	localparam logic [9:0]  ADDR_ISD      = {IDX_ISD, 2'b00};
	localparam logic [9:0]  ADDR_REV      = {IDX_REV, 2'b00};
	localparam logic [31:0] RESET_ISD     = 32'h0000_0000;
	localparam logic [31:0] RESET_REV     = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ISD_COAST_EN_BIT = 28;
	localparam int ISD_REV_EN_BIT   = 27;
	localparam int ISD_COAST_LSB    = 9;
	localparam int ISD_STAT_LSB     = 6;
	localparam int ISD_HOFF_LSB     = 2;
	localparam int ISD_RCUR_LSB     = 0;
	localparam int REV_RSVD_BIT     = 31;
	localparam int REV_A1_LSB       = 27;
	localparam int REV_A2_LSB       = 23;
	localparam int REV_BCUR_LSB     = 20;
	localparam int REV_KP_LSB       = 10;
	localparam int REV_KI_LSB       = 0;
	localparam logic [2:0] BCUR_RESERVED = 3'h7;

	// Gain scaling divisors
	localparam int KP_DIVISOR = 27;
	localparam int KI_DIVISOR = 29;

	typedef struct packed {
		logic       coast_enable;
		logic       reverse_drive_enable;
		logic [3:0] coast_duration;
		logic [2:0] stationary_bemf_threshold;
		logic [3:0] reverse_handoff_speed;
		logic [1:0] reversal_current_limit;
	} sdr_isd_s;

	typedef struct packed {
		logic [3:0] reverse_accel_first_order;
		logic [3:0] reverse_accel_second_order;
		logic [2:0] brake_current_limit;
		logic       brake_current_reserved;
		logic [9:0] braking_proportional_gain;
		logic [9:0] braking_integral_gain;
	} sdr_rev_s;

	typedef struct packed {
		logic [31:0] coast_duration_us;
		logic [15:0] stationary_bemf_mv;
		logic [9:0]  handoff_permille;
		logic [15:0] reversal_current_ma;
		logic [31:0] accel_first_mhz_s;
		logic [31:0] accel_second_mhz_s2;
		logic [15:0] brake_current_ma;
	} sdr_phys_s;

endpackage : sdr_pkg

// ### rtl/sdr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_decode
	import sdr_pkg::*;
(
	input  wire logic [31:0] isd_word,
	input  wire logic [31:0] rev_word,
	output var  sdr_isd_s    isd,
	output var  sdr_rev_s    rev,
	output var  sdr_phys_s   phys
);

	// ----------------------------------------
	// Shared table for the two accel fields
	// ----------------------------------------
	// Values in mHz/s; code 0 of the second order reads as zero
	function automatic logic [31:0] accel_mhz(input logic [3:0] c,
	                                          input logic second);
		case (c)
			4'h0: accel_mhz = second ? 32'h0 : 32'd10;
			4'h1: accel_mhz = 32'd50;
			4'h2: accel_mhz = 32'd1000;
			4'h3: accel_mhz = 32'd2500;
			4'h4: accel_mhz = 32'd5000;
			4'h5: accel_mhz = 32'd10000;
			4'h6: accel_mhz = 32'd25000;
			4'h7: accel_mhz = 32'd50000;
			4'h8: accel_mhz = 32'd75000;
			4'h9: accel_mhz = 32'd100000;
			4'ha: accel_mhz = 32'd250000;
			4'hb: accel_mhz = 32'd500000;
			4'hc: accel_mhz = 32'd750000;
			4'hd: accel_mhz = 32'd1000000;
			4'he: accel_mhz = 32'd5000000;
			default: accel_mhz = 32'd10000000;
		endcase
	endfunction

	always_comb begin
		isd.coast_enable              = isd_word[ISD_COAST_EN_BIT];
		isd.reverse_drive_enable      = isd_word[ISD_REV_EN_BIT];
		isd.coast_duration            = isd_word[ISD_COAST_LSB +: 4];
		isd.stationary_bemf_threshold = isd_word[ISD_STAT_LSB +: 3];
		isd.reverse_handoff_speed     = isd_word[ISD_HOFF_LSB +: 4];
		isd.reversal_current_limit    = isd_word[ISD_RCUR_LSB +: 2];
		rev.reverse_accel_first_order  = rev_word[REV_A1_LSB +: 4];
		rev.reverse_accel_second_order = rev_word[REV_A2_LSB +: 4];
		rev.brake_current_limit        = rev_word[REV_BCUR_LSB +: 3];
		rev.brake_current_reserved     = (rev_word[REV_BCUR_LSB +: 3]
		                                  == BCUR_RESERVED);
		rev.braking_proportional_gain  = rev_word[REV_KP_LSB +: 10];
		rev.braking_integral_gain      = rev_word[REV_KI_LSB +: 10];
	end

	always_comb begin
		case (isd.coast_duration)
			4'h0: phys.coast_duration_us = 32'd10000;
			4'h1: phys.coast_duration_us = 32'd50000;
			4'h2: phys.coast_duration_us = 32'd100000;
			4'h3: phys.coast_duration_us = 32'd200000;
			4'h4: phys.coast_duration_us = 32'd300000;
			4'h5: phys.coast_duration_us = 32'd400000;
			4'h6: phys.coast_duration_us = 32'd500000;
			4'h7: phys.coast_duration_us = 32'd750000;
			4'h8: phys.coast_duration_us = 32'd1000000;
			4'h9: phys.coast_duration_us = 32'd2000000;
			4'ha: phys.coast_duration_us = 32'd3000000;
			4'hb: phys.coast_duration_us = 32'd4000000;
			4'hc: phys.coast_duration_us = 32'd5000000;
			4'hd: phys.coast_duration_us = 32'd7500000;
			4'he: phys.coast_duration_us = 32'd10000000;
			default: phys.coast_duration_us = 32'd15000000;
		endcase
		case (isd.stationary_bemf_threshold)
			3'h0: phys.stationary_bemf_mv = 16'd50;
			3'h1: phys.stationary_bemf_mv = 16'd75;
			3'h2: phys.stationary_bemf_mv = 16'd100;
			3'h3: phys.stationary_bemf_mv = 16'd250;
			3'h4: phys.stationary_bemf_mv = 16'd500;
			3'h5: phys.stationary_bemf_mv = 16'd750;
			3'h6: phys.stationary_bemf_mv = 16'd1000;
			default: phys.stationary_bemf_mv = 16'd1500;
		endcase
		case (isd.reverse_handoff_speed)
			4'h0: phys.handoff_permille = 10'd25;
			4'h1: phys.handoff_permille = 10'd50;
			4'h2: phys.handoff_permille = 10'd75;
			4'h3: phys.handoff_permille = 10'd100;
			4'h4: phys.handoff_permille = 10'd125;
			4'h5: phys.handoff_permille = 10'd150;
			4'h6: phys.handoff_permille = 10'd200;
			4'h7: phys.handoff_permille = 10'd250;
			4'h8: phys.handoff_permille = 10'd300;
			4'h9: phys.handoff_permille = 10'd400;
			4'ha: phys.handoff_permille = 10'd500;
			4'hb: phys.handoff_permille = 10'd600;
			4'hc: phys.handoff_permille = 10'd700;
			4'hd: phys.handoff_permille = 10'd800;
			4'he: phys.handoff_permille = 10'd900;
			default: phys.handoff_permille = 10'd1000;
		endcase
		case (isd.reversal_current_limit)
			2'h0: phys.reversal_current_ma = 16'd938;
			2'h1: phys.reversal_current_ma = 16'd1563;
			2'h2: phys.reversal_current_ma = 16'd2188;
			default: phys.reversal_current_ma = 16'd3125;
		endcase
		phys.accel_first_mhz_s   = accel_mhz(rev.reverse_accel_first_order,
		                                     1'b0);
		phys.accel_second_mhz_s2 = accel_mhz(rev.reverse_accel_second_order,
		                                     1'b1);
		case (rev.brake_current_limit)
			3'h0: phys.brake_current_ma = 16'd313;
			3'h1: phys.brake_current_ma = 16'd625;
			3'h2: phys.brake_current_ma = 16'd1250;
			3'h3: phys.brake_current_ma = 16'd1875;
			3'h4: phys.brake_current_ma = 16'd2500;
			3'h5: phys.brake_current_ma = 16'd3125;
			3'h6: phys.brake_current_ma = 16'd3750;
			default: phys.brake_current_ma = 16'h0;
		endcase
	end

endmodule // sdr_decode
`default_nettype wire

// ### rtl/sdr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_regs
	import sdr_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output sdr_isd_s         isd_cfg,
	output sdr_rev_s         rev_cfg,
	output sdr_phys_s        phys_cfg,
	output logic             coast_active_en,
	output logic             reverse_drive_active_en,
	output logic             cfg_reserved_used
);

	// ----------------------------------------
	// Storage and write channel
	// ----------------------------------------
	logic [31:0] isd_reg;
	logic [31:0] rev_reg;
	logic [9:0]  waddr_reg;
	logic [1:0]  wr_hit;
	logic [1:0]  rd_hit;
	logic        aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        w_held_reg;
	logic        do_write;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [3:0]  strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
	endfunction

	// Word index decode; low address bits ignored, bit 1 set = REV word
	function automatic logic [1:0] reg_hit(input logic [9:0] a);
		reg_hit = {a[9:2] == IDX_REV, a[9:2] == IDX_ISD};
	endfunction

	assign wr_hit = reg_hit(waddr_reg);
	assign rd_hit = reg_hit(s_axi_araddr);

	// Address and data are taken in either order, then one write fires
	// Ready drops while frozen so no handshake is lost
	assign s_axi_awready = clk_en && !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = clk_en && !w_held_reg && !s_axi_bvalid;
	assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			waddr_reg   <= 10'h0;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (clk_en) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_hit != 2'b00) ? RESP_OKAY
				                                  : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	// Same decode as the response, so an OKAY write always lands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			isd_reg <= RESET_ISD;
			rev_reg <= RESET_REV;
		end else if (clk_en && do_write) begin
			if (wr_hit[0])
				isd_reg <= merge(isd_reg, wdata_reg, wstrb_reg);
			if (wr_hit[1])
				rev_reg <= merge(rev_reg, wdata_reg, wstrb_reg);
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign s_axi_arready = clk_en && !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (rd_hit != 2'b00) ? RESP_OKAY
				                                  : RESP_SLVERR;
				s_axi_rdata  <= rd_hit[0] ? isd_reg :
				                rd_hit[1] ? rev_reg : 32'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Field decode and enables
	// ----------------------------------------
	sdr_decode u_decode (
		.isd_word (isd_reg),
		.rev_word (rev_reg),
		.isd      (isd_cfg),
		.rev      (rev_cfg),
		.phys     (phys_cfg)
	);

	assign coast_active_en         = isd_cfg.coast_enable;
	assign reverse_drive_active_en = isd_cfg.reverse_drive_enable;
	// flag misuse, behaviour stays as stored
	assign cfg_reserved_used = rev_cfg.brake_current_reserved |
	                           rev_reg[REV_RSVD_BIT];

endmodule // sdr_regs
`default_nettype wire

// ### dv/sdr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register bank checks
// ----------------------------------------
module sdr_regs_chk
	import sdr_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [9:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire sdr_isd_s    isd_cfg,
	input wire sdr_rev_s    rev_cfg,
	input wire sdr_phys_s   phys_cfg,
	input wire logic        coast_active_en,
	input wire logic        reverse_drive_active_en,
	input wire logic        cfg_reserved_used
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst;
		$rose(aresetn) |-> rev_cfg == '0 && isd_cfg == '0 && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_unm;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] != IDX_ISD &&
		s_axi_araddr[9:2] != IDX_REV |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read answered");
	property p_rev;
		reverse_drive_active_en == isd_cfg.reverse_drive_enable;
	endproperty
	a_rev: assert property (p_rev) else $error("reverse enable wrong");
	property p_coast;
		coast_active_en == isd_cfg.coast_enable;
	endproperty
	a_coast: assert property (p_coast) else $error("coast enable wrong");
	property p_bcur;
		rev_cfg.brake_current_limit == BCUR_RESERVED |->
		cfg_reserved_used && phys_cfg.brake_current_ma == '0;
	endproperty
	a_bcur: assert property (p_bcur) else $error("reserved brake code");
	property p_hiz;
		isd_cfg.coast_duration == 4'hf |-> phys_cfg.coast_duration_us == 32'd15000000;
	endproperty
	a_hiz: assert property (p_hiz) else $error("longest coast wrong");
	c_rev: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_REV);
	c_unm: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_rsv: cover property (cfg_reserved_used);
endmodule // sdr_regs_chk
bind sdr_regs sdr_regs_chk u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
	.isd_cfg, .rev_cfg, .phys_cfg, .coast_active_en, .reverse_drive_active_en,
	.cfg_reserved_used);
`default_nettype wire

// ### dv/test_speed_detect_reverse_drive_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module test_speed_detect_reverse_drive_cfg
	import sdr_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        coast_active_en, reverse_drive_active_en, cfg_reserved_used;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rev_w;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	sdr_isd_s    isd_cfg;
	sdr_rev_s    rev_cfg;
	sdr_phys_s   phys_cfg;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          bad_count, cmp_count, seed;
	int          t_hiz[16] = '{10000, 50000, 100000, 200000, 300000, 400000,
		500000, 750000, 1000000, 2000000, 3000000, 4000000, 5000000, 7500000,
		10000000, 15000000};
	int          t_acc[16] = '{10, 50, 1000, 2500, 5000, 10000, 25000, 50000,
		75000, 100000, 250000, 500000, 750000, 1000000, 5000000, 10000000};
	int          t_hof[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400,
		500, 600, 700, 800, 900, 1000};
	int          t_mv[8]   = '{50, 75, 100, 250, 500, 750, 1000, 1500};
	int          t_brk[8]  = '{313, 625, 1250, 1875, 2500, 3125, 3750, 0};
	int          t_cur[4]  = '{938, 1563, 2188, 3125};
	logic        clk_en = 1'b1;
	logic [2:0]  prot = 3'h0;

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	sdr_regs dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awprot(prot),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.isd_cfg, .rev_cfg, .phys_cfg, .coast_active_en,
		.reverse_drive_active_en, .cfg_reserved_used);

	// ----------------------------------------
	// Compare and verdict
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (e !== s) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic summarize;
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Bus master, one idle edge between transfers
	// ----------------------------------------
	task automatic wr(input logic [9:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] r);
		@(posedge aclk);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel is released at its own handshake
		fork
			begin
				@(posedge aclk iff s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				@(posedge aclk iff s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		@(posedge aclk iff s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] v,
		input logic [1:0] r);
		@(posedge aclk);
		rq.push_back({r, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(posedge aclk iff s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// Random stall makes the slave hold its read answer
		if ($random(seed) & 1)
			@(posedge aclk);
		s_axi_rready <= 1'b1;
		@(posedge aclk iff s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	// Answers are taken at the handshake edge, oldest note first
	always @(posedge aclk) begin
		logic [33:0] e;
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			chk("rdata", e[31:0], s_axi_rdata);
			chk("rresp", 32'(e[33:32]), 32'(s_axi_rresp));
		end
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
	end

	initial begin
		#40000;
		bad_count++;
		summarize();
	end

	initial begin
		seed = 32'hf3fe44b8;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr} = 21'h0;
		{s_axi_wdata, s_axi_wstrb} = 36'h0;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_REV, 32'h0, RESP_OKAY);
		rd(ADDR_ISD, 32'h0, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			// reserved bit and code kept clear
			d = $random(seed) & 32'h7fff_ffff;
			if (d[22:20] == 3'h7)
				d[20] = 1'b0;
			wr(ADDR_REV, d, 4'hf, RESP_OKAY);
			rd(ADDR_REV, d, RESP_OKAY);
			@(negedge aclk);
			chk("a1", 32'(d[30:27]),
				32'(rev_cfg.reverse_accel_first_order));
			chk("a2", 32'(d[26:23]),
				32'(rev_cfg.reverse_accel_second_order));
			chk("bcur", 32'(d[22:20]),
				32'(rev_cfg.brake_current_limit));
			chk("kp", 32'(d[19:10]),
				32'(rev_cfg.braking_proportional_gain));
			chk("ki", 32'(d[9:0]),
				32'(rev_cfg.braking_integral_gain));
		end
		// Byte lane merge, reserved top bit kept as storage
		rev_w = {8'h80, d[23:16], ~d[15:8], d[7:0]};
		wr(ADDR_REV, ~d, 4'h2, RESP_OKAY);
		wr(ADDR_REV, 32'h8000_0000, 4'h8, RESP_OKAY);
		rd(ADDR_REV, rev_w, RESP_OKAY);
		@(negedge aclk);
		chk("rsv", 32'h1, 32'(cfg_reserved_used));
		wr(10'h210, $random(seed), 4'hf, RESP_SLVERR);
		rd(10'h210, 32'h0, RESP_SLVERR);
		rd(10'h204, 32'h0, RESP_SLVERR);
		rd(ADDR_REV, rev_w, RESP_OKAY);
		// Mid-run reset must clear both words again
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_REV, 32'h0, RESP_OKAY);
		rd(ADDR_ISD, 32'h0, RESP_OKAY);
		// Every code of each table field except second-order accel code 14, enables walked through all four pairs
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_ISD, (i[1:0] << 27) | (i << 9) | (i[2:0] << 6) | (i << 2) | i[1:0],
				4'hf, RESP_OKAY);
			wr(ADDR_REV, (i << 27) | (i << 23) | (i[2:0] << 20) | (i << 10) | i,
				4'hf, RESP_OKAY);
			@(negedge aclk);
			chk("coast_en", 32'(i[1]), 32'(coast_active_en));
			chk("rev_en", 32'(i[0]), 32'(reverse_drive_active_en));
			chk("hiz", 32'(t_hiz[i]), phys_cfg.coast_duration_us);
			chk("stat", 32'(t_mv[i[2:0]]), 32'(phys_cfg.stationary_bemf_mv));
			chk("hoff", 32'(t_hof[i]), 32'(phys_cfg.handoff_permille));
			chk("rcur", 32'(t_cur[i[1:0]]),
				32'(phys_cfg.reversal_current_ma));
			chk("acc1", 32'(t_acc[i]), phys_cfg.accel_first_mhz_s);
			if (i != 14)
				chk("acc2", i == 0 ? 32'h0 : 32'(t_acc[i]), phys_cfg.accel_second_mhz_s2);
			chk("brk", 32'(t_brk[i[2:0]]),
				32'(phys_cfg.brake_current_ma));
			chk("rsv", 32'(i[2:0] == 3'h7), 32'(cfg_reserved_used));
		end
		summarize();
	end
endmodule // test_speed_detect_reverse_drive_cfg
`default_nettype wire
